//--- tb/kee_link_asserts.sv
// Protocol checks on the link between key encoder and host
`timescale 1ns/1ps
module kee_link_asserts (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe,
	input wire logic sda_host_oe,
	input wire logic key_event_irq_n,
	input wire logic protocol_select
);
	logic scl_r;
	logic [3:0] rise_r;
	logic [3:0] rise_nxt;
	wire logic rise = scl & ~scl_r;
	// Count link clock rises while the interrupt is low
	always_comb
	begin
		rise_nxt = key_event_irq_n ? 4'h0 : rise_r + {3'h0, rise};
	end
	// Register the edge detector and counter
	always_ff @(posedge clk_sys_in)
	begin
		scl_r <= rst_n_in ? scl : 1'b1;
		rise_r <= rst_n_in ? rise_nxt : 4'h0;
	end
	////////////////////////////////////////
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	a_irq_holds: assert property ($fell(key_event_irq_n) |->
		!key_event_irq_n [*8]) else $error("irq low too short");
	a_wait_start: assert property ($fell(key_event_irq_n) |->
		!sda_dev_oe [*8]) else $error("data before start");
	a_start_cond: assert property ($rose(sda_host_oe) |->
		scl && !key_event_irq_n) else $error("bad start bit");
	a_first_bit: assert property ((rise && rise_r == 4'h0
		&& !key_event_irq_n) |-> sda_dev_oe) else $error("no bit");
	a_bit_stable: assert property ((scl && $past(scl) && sda_dev_oe
		&& $past(sda_dev_oe)) |-> $stable(sda_dev_o))
		else $error("data moved while clock high");
	a_ninth_zero: assert property ((rise && rise_r == 4'h8) |->
		!sda) else $error("ninth bit high");
	a_nine_bits: assert property (($rose(key_event_irq_n) &&
		protocol_select) |-> rise_r == 4'h9)
		else $error("irq released early");
	a_irq_release: assert property ((rise && rise_r == 4'h8) |->
		##[1:12] key_event_irq_n) else $error("irq not released");
	a_sda_quiet: assert property ((key_event_irq_n &&
		$past(key_event_irq_n, 4)) |-> !sda_dev_oe)
		else $error("data driven while idle");
endmodule

//--- tb/key_event_encoder_serial_bench.sv
// Self-checking bench: key encoder and host joined by the link
`timescale 1ns/1ps
`define CHK(n, e, g) \
begin \
	comparisons++; \
	if ((g) !== 8'(e)) \
	begin \
		fails++; \
		$display("ERROR %s exp %h seen %h", n, 8'(e), g); \
	end \
end
module key_event_encoder_serial_bench
	import kee_pkg::*;
;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [NKEY-1:0] keys = '0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic irq;
	logic proto = 1'b1;
	logic dev_rd = 1'b0;
	logic [7:0] dev_rdata;
	int fails = 0;
	int comparisons = 0;
	int cyc = 0;
	int row_of[NCOL];
	logic [7:0] exp_q[$];
	kee_link_if link();
	kee_device kee_device_i(.link(link), .clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in), .key_state_in(keys),
		.protocol_select_in(proto), .reg_addr_in(addr),
		.reg_rd_in(dev_rd), .reg_rdata_out(dev_rdata));
	kee_host kee_host_i(.link(link), .clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.irq_out(irq));
	kee_link_asserts kee_link_asserts_i(.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in), .scl(link.scl), .sda(link.sda),
		.sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe),
		.sda_host_oe(link.sda_host_oe), .protocol_select(proto),
		.key_event_irq_n(link.key_event_irq_n));
	////////////////////////////////////////
	// Clock and hang guard
	initial
		forever #5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			fails++;
			print_verdict();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Host register port cycles
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
	endtask
	// Reads the host port, or the device port when dev is set
	task automatic chk_reg(input string n, input logic [7:0] a, int e,
		input bit dev = 1'b0);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= ~dev;
		dev_rd <= dev;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		dev_rd <= 1'b0;
		#1;
		if (dev)
			`CHK(n, e, dev_rdata)
		else
			`CHK(n, e, rdata)
	endtask
	// Flip one switch; the model queues its code when one is due
	task automatic toggle(input int r, input int c, input bit rep);
		int k;
		k = r * NCOL + c;
		if (rep)
		begin
			exp_q.push_back(8'((keys[k] ? 128 : 0) + r * 16 + c + 1));
			row_of[c] = keys[k] ? -1 : r;
		end
		@(posedge clk_sys_in);
		keys[k] <= ~keys[k];
	endtask
	// Await the interrupt, then read and clear one code
	task automatic xfer();
		int i;
		i = 0;
		while (irq !== 1'b1 && i < 2000)
		begin
			@(posedge clk_sys_in);
			#1;
			i++;
		end
		chk_reg("status", HREG_STAT, 1);
		chk_reg("code", HREG_CODE, exp_q.pop_front());
		wr_reg(HREG_STAT, 8'h01);
		chk_reg("cleared", HREG_STAT, 0);
		`CHK("irq", 0, irq)
	endtask
	////////////////////////////////////////
	// Main sequence
	initial
	begin
		int r;
		int c;
		logic [31:0] seed;
		seed = 32'hE0C4B656;
		for (int j = 0; j < NCOL; j++)
			row_of[j] = -1;
		repeat (8) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		wr_reg(HREG_CTRL, 8'h01);
		chk_reg("unmapped", 8'h07, 0);
		chk_reg("ctrl", HREG_CTRL, 1);
		toggle(0, 0, 1);
		repeat (1000) @(posedge clk_sys_in);
		#1;
		`CHK("masked", 0, irq)
		wr_reg(HREG_MASK, 8'h01);
		xfer();
		toggle(0, 11, 1);
		xfer();
		// Long enough for a wrongly reported code to finish its transfer
		toggle(1, 0, 0);
		repeat (700) @(posedge clk_sys_in);
		#1;
		`CHK("ghost", 0, irq)
		toggle(1, 0, 0);
		repeat (700) @(posedge clk_sys_in);
		#1;
		`CHK("unghost", 0, irq)
		repeat (40)
		begin
			seed = lfsr(seed);
			r = int'(seed[2:0]);
			c = int'(seed[15:8]) % NCOL;
			if (keys[r * NCOL + c] || row_of[c] < 0)
			begin
				toggle(r, c, 1);
				xfer();
			end
		end
		// Register mode: the select moves only while reset is held
		@(posedge clk_sys_in);
		rst_n_in <= 1'b0;
		proto <= 1'b0;
		keys <= '0;
		repeat (8) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		toggle(2, 3, 1);
		repeat (200) @(posedge clk_sys_in);
		chk_reg("waiting", REG_FIFO, 1, 1);
		chk_reg("keycode", REG_KEYCODE, exp_q.pop_front(), 1);
		chk_reg("drained", REG_FIFO, 0, 1);
		chk_reg("empty", REG_KEYCODE, 0, 1);
		print_verdict();
	end
endmodule

//--- verilog/kee_device.sv
// Key event encoder: matrix change detection and three-wire sender
`timescale 1ns/1ps
module kee_device
	import kee_pkg::*;
(
	kee_link_if.dev link,
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [NKEY-1:0] key_state_in,
	input wire logic protocol_select_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out
);
	typedef struct packed {
		kee_dev_st_t st;
		logic [NKEY-1:0] reported;
		logic [2:0] row;
		logic [3:0] col;
		logic pending;
		logic [CODE_W-1:0] code;
		logic [CODE_W-1:0] shreg;
		logic [3:0] bitcnt;
		logic sda_o;
		logic sda_oe;
		logic irq_oe;
		logic scl_d;
		logic sda_d;
		logic [7:0] rdata;
	} kee_dev_state_t;

	kee_dev_state_t s_r;
	kee_dev_state_t s_nxt;
	logic [NKEY-1:0] keys_s;
	logic [2:0] pins_s;
	logic proto_s;
	logic scl_s;
	logic sda_s;
	logic [6:0] key_idx;
	logic key_now;
	logic key_was;
	logic ghost;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;

	////////////////////////////////////////////////////////////////////
	// Ghost test: per row pair, a shared column plus any second column
	function automatic logic kee_ghost(input logic [NKEY-1:0] k);
		logic [NCOL-1:0] a;
		logic [NCOL-1:0] b;
		logic [NCOL-1:0] both;
		logic [NCOL-1:0] any;
		logic g;
		a = '0;
		b = '0;
		both = '0;
		any = '0;
		g = 1'b0;
		for (int r1 = 0; r1 < NROW; r1++)
		begin
			for (int r2 = r1 + 1; r2 < NROW; r2++)
			begin
				a = k[r1*NCOL +: NCOL];
				b = k[r2*NCOL +: NCOL];
				both = a & b;
				any = a | b;
				g = g | ((|both) & (|(any & (any - 1'b1))));
			end
		end
		return g;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Synchronisers for key levels and link pins
	kee_sync #(
		.W(NKEY),
		.RST_VAL('0)
	) u_key_sync (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.d_in(key_state_in),
		.q_out(keys_s)
	);

	kee_sync #(
		.W(3),
		.RST_VAL(3'h7)
	) u_pin_sync (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.d_in({protocol_select_in, link.scl, link.sda}),
		.q_out(pins_s)
	);

	assign proto_s = pins_s[2];
	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	////////////////////////////////////////////////////////////////////
	// Scan position, edges of the host clock and start condition
	assign key_idx = 7'(int'(s_r.row) * NCOL + int'(s_r.col));
	assign key_now = keys_s[key_idx];
	assign key_was = s_r.reported[key_idx];
	assign ghost = kee_ghost(keys_s);
	assign scl_rise = scl_s & ~s_r.scl_d;
	assign scl_fall = ~scl_s & s_r.scl_d;
	assign start_seen = scl_s & s_r.sda_d & ~sda_s;

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.scl_d = scl_s;
		s_nxt.sda_d = sda_s;
		s_nxt.rdata = 8'h00;
		// Scanner walks one switch a cycle, stalls while a code waits
		if (!s_r.pending)
		begin
			if ((key_now != key_was) && !ghost)
			begin
				s_nxt.pending = 1'b1;
				s_nxt.reported[key_idx] = key_now;
				s_nxt.code = {~key_now, s_r.row, 4'(s_r.col + COL_BASE)};
			end
			else if (s_r.col == COL_LAST)
			begin
				s_nxt.col = 4'h0;
				s_nxt.row = (s_r.row == ROW_LAST) ? 3'h0 : 3'(s_r.row + 3'h1);
			end
			else
			begin
				s_nxt.col = 4'(s_r.col + 4'h1);
			end
		end
		// Register-mode reads; the code read pops the waiting code
		if (reg_rd_in)
		begin
			if (reg_addr_in == REG_KEYCODE)
			begin
				s_nxt.rdata = s_r.pending ? s_r.code : 8'h00;
				if (!proto_s && s_r.pending && s_r.st == DEV_IDLE)
				begin
					s_nxt.pending = 1'b0;
				end
			end
			else if (reg_addr_in == REG_FIFO)
			begin
				s_nxt.rdata = {7'h00, s_r.pending};
			end
		end
		// Link transfer
		case (s_r.st)
			DEV_IDLE:
			begin
				s_nxt.sda_oe = 1'b0;
				if (s_r.pending && proto_s)
				begin
					s_nxt.st = DEV_WAIT_START;
					s_nxt.shreg = s_r.code;
					s_nxt.bitcnt = 4'h0;
				end
			end
			DEV_WAIT_START:
			begin
				if (start_seen)
				begin
					s_nxt.st = DEV_SHIFT;
				end
			end
			DEV_SHIFT:
			begin
				if (scl_fall)
				begin
					// Zero fill makes the ninth bit low
					s_nxt.sda_o = s_r.shreg[CODE_W-1];
					s_nxt.shreg = {s_r.shreg[CODE_W-2:0], 1'b0};
					s_nxt.sda_oe = 1'b1;
				end
				else if (scl_rise)
				begin
					if (s_r.bitcnt == LAST_BIT)
					begin
						s_nxt.st = DEV_IDLE;
						s_nxt.pending = 1'b0;
						s_nxt.sda_oe = 1'b0;
					end
					else
					begin
						s_nxt.bitcnt = 4'(s_r.bitcnt + 4'h1);
					end
				end
			end
			default:
			begin
				s_nxt.st = DEV_IDLE;
			end
		endcase
		// Interrupt low while a code waits, released once it is sent, or in register mode once it is read
		s_nxt.irq_oe = s_nxt.pending;
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
		begin
			s_r <= '0;
			s_r.st <= DEV_IDLE;
			s_r.scl_d <= 1'b1;
			s_r.sda_d <= 1'b1;
			s_r.sda_o <= 1'b1;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign link.sda_dev_o = s_r.sda_o;
	assign link.sda_dev_oe = s_r.sda_oe;
	assign link.irq_dev_o = 1'b0;
	assign link.irq_dev_oe = s_r.irq_oe;
	assign reg_rdata_out = s_r.rdata;
endmodule

//--- verilog/kee_host.sv
// Host controller that reads key codes over the three-wire link
`timescale 1ns/1ps
module kee_host
	import kee_pkg::*;
(
	kee_link_if.host link,
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output logic irq_out
);
	typedef struct packed {
		kee_host_st_t st;
		logic enable;
		logic [STAT_W-1:0] stat;
		logic [STAT_W-1:0] mask;
		logic [CODE_W-1:0] code;
		logic [XFER_BITS-1:0] shreg;
		logic [3:0] bitcnt;
		logic [7:0] timer;
		logic scl;
		logic sda_oe;
		logic [7:0] rdata;
	} kee_host_state_t;

	kee_host_state_t s_r;
	kee_host_state_t s_nxt;
	logic [1:0] pins_s;
	logic irq_s;
	logic sda_s;
	logic tdone;

	kee_sync #(
		.W(2),
		.RST_VAL(2'h3)
	) u_pin_sync (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.d_in({link.key_event_irq_n, link.sda}),
		.q_out(pins_s)
	);

	assign irq_s = pins_s[1];
	assign sda_s = pins_s[0];
	assign tdone = (s_r.timer == 8'h00);

	////////////////////////////////////////////////////////////////////
	// Register port, then the link sequencer
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.rdata = 8'h00;
		s_nxt.timer = tdone ? 8'h00 : 8'(s_r.timer - 8'h01);
		if (reg_wr_in)
		begin
			case (reg_addr_in)
				HREG_CTRL: s_nxt.enable = reg_wdata_in[0];
				HREG_STAT: s_nxt.stat = s_r.stat & ~reg_wdata_in[STAT_W-1:0];
				HREG_MASK: s_nxt.mask = reg_wdata_in[STAT_W-1:0];
				default: s_nxt.stat = s_nxt.stat;
			endcase
		end
		if (reg_rd_in)
		begin
			case (reg_addr_in)
				HREG_CTRL: s_nxt.rdata = {7'h00, s_r.enable};
				HREG_STAT: s_nxt.rdata = {6'h00, s_r.stat};
				HREG_MASK: s_nxt.rdata = {6'h00, s_r.mask};
				HREG_CODE: s_nxt.rdata = s_r.code;
				default: s_nxt.rdata = 8'h00;
			endcase
		end
		case (s_r.st)
			HOST_IDLE:
			begin
				if (s_r.enable && !irq_s)
				begin
					s_nxt.st = HOST_START;
					s_nxt.sda_oe = 1'b1;
					s_nxt.timer = SCL_HALF_CYC;
				end
			end
			HOST_START:
			begin
				if (tdone)
				begin
					s_nxt.st = HOST_LOW;
					s_nxt.scl = 1'b0;
					s_nxt.sda_oe = 1'b0;
					s_nxt.bitcnt = 4'h0;
					s_nxt.timer = SCL_HALF_CYC;
				end
			end
			HOST_LOW:
			begin
				if (tdone)
				begin
					// Sample as the clock rises: the device frees the
					// data line soon after the ninth rise
					s_nxt.shreg = {s_r.shreg[XFER_BITS-2:0], sda_s};
					s_nxt.st = HOST_HIGH;
					s_nxt.scl = 1'b1;
					s_nxt.timer = SCL_HALF_CYC;
				end
			end
			HOST_HIGH:
			begin
				if (tdone)
				begin
					s_nxt.timer = SCL_HALF_CYC;
					if (s_r.bitcnt == LAST_BIT)
					begin
						s_nxt.st = HOST_END;
						s_nxt.code = s_r.shreg[XFER_BITS-1:1];
						s_nxt.stat[STAT_RX] = 1'b1;
						s_nxt.stat[STAT_ERR] = s_nxt.stat[STAT_ERR] | s_r.shreg[0];
					end
					else
					begin
						s_nxt.st = HOST_LOW;
						s_nxt.scl = 1'b0;
						s_nxt.bitcnt = 4'(s_r.bitcnt + 4'h1);
					end
				end
			end
			HOST_END:
			begin
				// Gives the device time to release the interrupt
				if (tdone)
				begin
					s_nxt.st = HOST_IDLE;
				end
			end
			default:
			begin
				s_nxt.st = HOST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
		begin
			s_r <= '0;
			s_r.st <= HOST_IDLE;
			s_r.scl <= 1'b1;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign link.scl = s_r.scl;
	assign link.sda_host_o = 1'b0;
	assign link.sda_host_oe = s_r.sda_oe;
	assign reg_rdata_out = s_r.rdata;
	assign irq_out = |(s_r.stat & s_r.mask);
endmodule

//--- verilog/kee_link_if.sv
// Three-wire link between the key encoder and its host
`timescale 1ns/1ps
interface kee_link_if;
	logic scl;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic irq_dev_o;
	logic irq_dev_oe;
	logic sda;
	logic key_event_irq_n;
	// Pulled-up wires: low while any driver pulls low
	assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));
	assign key_event_irq_n = ~(irq_dev_oe & ~irq_dev_o);
	modport dev (input scl, input sda, output sda_dev_o,
		output sda_dev_oe, output irq_dev_o, output irq_dev_oe);
	modport host (output scl, input sda, input key_event_irq_n,
		output sda_host_o, output sda_host_oe);
endinterface

//--- verilog/kee_pkg.sv
// Shared constants and state types for the key event encoder link
// Summary of operation
// - Code: row in 6:4, column plus one 3:0
// - Press code has bit 7 clear
// - Release code has bit 7 set
// - Only changed keys produce a code
// - Three rectangle corners pressed: report nothing
// - Any ghost-free key count is reported
// - Protocol select held constant; high means link
// - Host never switches protocol while running
// - Scan setup fixed at initialisation only
// - Key event drives interrupt line low
// - Host sends start bit after interrupt
// - Ninth bit always zero, nine clocks
// - Interrupt released after the ninth bit
// - Register mode: oldest code at 0x14
package kee_pkg;
	// Matrix geometry and code layout
	localparam int NROW = 8;
	localparam int NCOL = 12;
	localparam int NKEY = NROW * NCOL;
	localparam int CODE_W = 8;
	localparam int XFER_BITS = 9;
	localparam logic [3:0] LAST_BIT = 4'h8;
	localparam logic [3:0] COL_LAST = 4'hB;
	localparam logic [3:0] COL_BASE = 4'h1;
	localparam logic [2:0] ROW_LAST = 3'h7;
	// Device register-mode read map
	localparam logic [7:0] REG_KEYCODE = 8'h14;
	localparam logic [7:0] REG_FIFO = 8'h15;
	// Host controller register map
	localparam logic [7:0] HREG_CTRL = 8'h00;
	localparam logic [7:0] HREG_STAT = 8'h01;
	localparam logic [7:0] HREG_MASK = 8'h02;
	localparam logic [7:0] HREG_CODE = 8'h03;
	localparam int STAT_W = 2;
	localparam int STAT_RX = 0;
	localparam int STAT_ERR = 1;
	// Link clock half period made by the host divider
	localparam int CLK_NS = 10;
	localparam int SCL_HALF_NS = 200;
	localparam int SCL_HALF_I = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] SCL_HALF_CYC = 8'(SCL_HALF_I);
	// State machines
	typedef enum logic [1:0] {DEV_IDLE, DEV_WAIT_START, DEV_SHIFT}
		kee_dev_st_t;
	typedef enum logic [2:0] {HOST_IDLE, HOST_START, HOST_LOW, HOST_HIGH,
		HOST_END} kee_host_st_t;
endpackage

//--- verilog/kee_sync.sv
// Two-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module kee_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
)(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// First flop feeds only the second
	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
		begin
			meta_r <= RST_VAL;
			q_r <= RST_VAL;
		end
		else
		begin
			meta_r <= d_in;
			q_r <= meta_r;
		end
	end

	assign q_out = q_r;
endmodule
